//--- hw/eeprom_access_guard_defs.svh
// constants and overview for the eeprom access guard
// Overview of operation
// R1: reset clears program permit bit
// R2: reset zeroes both pointer high bytes
// R3: control register only in sector 1
// R4: control register at low address 040H
// R5: write end sets done flag always
// R6: vector needs flag, enables, stack room
// R7: servicing clears done flag automatically
// R8: software sets go right after permit
// R9: software masks global irq around start
// R10: software avoids halt during cycles
// R11: software reloads address every read
// R12: software keeps permit low, pointers zero
// R13: go bits self clear; need permit
// R14: software never sets both go bits
// R15: address register six bits, upper zero
// R16: fetched byte held until next cycle
`ifndef EEPROM_ACCESS_GUARD_DEFS_SVH
`define EEPROM_ACCESS_GUARD_DEFS_SVH

`define CTRL_SECTOR       8'h01
`define CTRL_LOW_ADDR     8'h40
`define PTR_HIGH_RST      8'h00
`define ADDR_RST          6'h00
`define DATA_RST          8'h00
`define CTRL_RST          4'h0
// register select codes on the software access port
`define SEL_ADDR          3'h0
`define SEL_DATA          3'h1
`define SEL_PTR1H         3'h2
`define SEL_PTR2H         3'h3
`define SEL_IND1          3'h4
`define SEL_IND2          3'h5
`define BIT_FETCH_GO      2'd0
`define BIT_FETCH_PERMIT  2'd1
`define BIT_PROG_GO       2'd2
`define BIT_PROG_PERMIT   2'd3
`define READ_CYCLES       4'd4
`define WRITE_TIME_NS     2000
`define CLK_PERIOD_NS     4
`define WRITE_CYCLES      ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- hw/eeprom_access_guard_pkg.sv
// types shared by the eeprom access guard
package eeprom_access_guard_pkg;
	// software register access from the core
	typedef struct packed {
		logic       wr;     // write strobe
		logic       rd;     // read strobe
		logic [2:0] sel;    // 0 addr,1 data,2 ptr1h,3 ptr2h,4 indirect1,5 indirect2
		logic [7:0] wdata;  // write data
	} sfr_req_t;
	// pointer low bytes seen by the indirect decoder
	typedef struct packed {
		logic [7:0] ptr1_low;
		logic [7:0] ptr2_low;
	} ptr_low_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_READ  = 3'b010,
		ST_WRITE = 3'b100
	} cyc_state_t;
endpackage

//--- hw/nvm_cell_array.sv
// 64 byte storage array with timed read and write cycles
`include "eeprom_access_guard_defs.svh"
module nvm_cell_array
	import eeprom_access_guard_pkg::*;
(
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	// cycle requests
	input  wire logic       i_start_rd,
	input  wire logic       i_start_wr,
	input  wire logic [5:0] i_addr,
	input  wire logic [7:0] i_wdata,
	// cycle results
	output logic            o_rd_done,
	output logic            o_wr_done,
	output logic [7:0]      o_rdata
);
	logic [7:0]  mem [64];      // cells survive reset, like real nonvolatile storage
	cyc_state_t  st_r, st_nxt;  // cycle state
	logic [11:0] cnt_r, cnt_nxt;// cycle timer
	logic [5:0]  a_r, a_nxt;    // latched address
	logic [7:0]  d_r, d_nxt;    // latched data
	logic        rdn_r, rdn_nxt, wdn_r, wdn_nxt;
	logic [7:0]  q_r, q_nxt;

	assign o_rd_done = rdn_r;
	assign o_wr_done = wdn_r;
	assign o_rdata   = q_r;

	// next state of the cycle engine
	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r;
		a_nxt   = a_r;
		d_nxt   = d_r;
		rdn_nxt = 1'b0;
		wdn_nxt = 1'b0;
		q_nxt   = q_r;
		unique case (st_r)
			ST_IDLE: begin
				if (i_start_rd) begin
					st_nxt  = ST_READ;
					cnt_nxt = 12'(`READ_CYCLES);
					a_nxt   = i_addr;
				end else if (i_start_wr) begin
					st_nxt  = ST_WRITE;
					cnt_nxt = 12'(`WRITE_CYCLES);
					a_nxt   = i_addr;
					d_nxt   = i_wdata;
				end
			end
			ST_READ: begin
				cnt_nxt = cnt_r - 12'h001;
				if (cnt_r == 12'h001) begin
					st_nxt  = ST_IDLE;
					rdn_nxt = 1'b1;
					q_nxt   = mem[a_r];
				end
			end
			ST_WRITE: begin
				cnt_nxt = cnt_r - 12'h001;
				if (cnt_r == 12'h001) begin
					st_nxt  = ST_IDLE;
					wdn_nxt = 1'b1;
				end
			end
			default: st_nxt = ST_IDLE; // illegal code recovers to idle
		endcase
	end

	// register the engine
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st_r  <= ST_IDLE;
			cnt_r <= 12'h000;
			a_r   <= 6'h00;
			d_r   <= 8'h00;
			rdn_r <= 1'b0;
			wdn_r <= 1'b0;
			q_r   <= 8'h00;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
			a_r   <= a_nxt;
			d_r   <= d_nxt;
			rdn_r <= rdn_nxt;
			wdn_r <= wdn_nxt;
			q_r   <= q_nxt;
		end
	end

	// storage commits at the end of the write timer
	always_ff @(posedge i_mclk) begin
		if (st_r == ST_WRITE && cnt_r == 12'h001) begin
			mem[a_r] <= d_r;
		end
	end
endmodule

//--- hw/eeprom_access_guard.sv
// software access guard for the 64 byte data eeprom
`include "eeprom_access_guard_defs.svh"
module eeprom_access_guard
	import eeprom_access_guard_pkg::*;
(
	// clock and reset
	input  wire logic                           i_mclk,
	input  wire logic                           i_rst,
	// special function register access
	input  wire eeprom_access_guard_pkg::sfr_req_t i_sfr,
	input  wire eeprom_access_guard_pkg::ptr_low_t i_ptr_low,
	output logic [7:0]                          o_sfr_rdata,
	// interrupt side
	input  wire logic                           i_nvm_done_irq_enable,
	input  wire logic                           i_global_irq_enable,
	input  wire logic                           i_stack_full,
	input  wire logic                           i_irq_serviced,
	output logic                                o_nvm_done_irq_flag,
	output logic                                o_irq_vector_req,
	// status
	output logic                                o_busy
);
	// directly addressed registers
	logic [5:0] nvm_address_reg_r;    // eeprom address, upper two bits do not exist
	logic [5:0] addr_nxt;             // next address
	logic [7:0] nvm_data_reg_r;       // eeprom data, also holds the fetched byte
	logic [7:0] data_nxt;             // next data
	logic [7:0] pointer1_high_byte_r; // sector select of pointer 1
	logic [7:0] p1h_nxt;              // next pointer 1 high byte
	logic [7:0] pointer2_high_byte_r; // sector select of pointer 2
	logic [7:0] p2h_nxt;              // next pointer 2 high byte
	// control register
	logic [3:0] nvm_control_reg_r;    // program permit, program go, fetch permit, fetch go
	logic [3:0] ctrl_nxt;             // next control value
	// interrupt and status state
	logic       flag_r;               // write done request
	logic       flag_nxt;             // next request
	logic       vec_r;                // vector request towards the core
	logic       vec_nxt;              // next vector request
	logic [7:0] rdata_r;              // registered read data
	logic [7:0] rdata_nxt;            // read mux output
	logic       busy_r;               // a read or write cycle is running
	logic       busy_nxt;             // next busy
	// cycle engine handshake
	logic       start_rd;             // launch a read cycle this clock
	logic       start_wr;             // launch a write cycle this clock
	logic       rd_done;              // read cycle ended, byte stands on arr_q
	logic       wr_done;              // write cycle ended
	logic [7:0] arr_q;                // byte fetched by the last read cycle
	// control register decode
	logic       ctrl_hit1;            // pointer 1 aims at the control register
	logic       ctrl_hit2;            // pointer 2 aims at the control register
	logic       ctrl_sel;             // this access goes to the control register
	logic       ctrl_wr;              // software writes the control register
	logic       go_fetch;             // accepted fetch go request
	logic       go_prog;              // accepted program go request

	// true when an indirect access lands on the control register
	// the sector check keeps stray pointer traffic away from the go bits
	function automatic logic hits_ctrl(input logic [7:0] hi, input logic [7:0] lo);
		return (hi == `CTRL_SECTOR) && (lo == `CTRL_LOW_ADDR); // R3 R4
	endfunction

	// a go bit may start a cycle only with its permit stored and no cycle running
	function automatic logic go_ok(input logic req, input logic permit, input logic busy);
		return req && permit && !busy; // R13
	endfunction

	// indirect decode, either pointer pair may reach the control register
	assign ctrl_hit1 = hits_ctrl(pointer1_high_byte_r, i_ptr_low.ptr1_low);
	assign ctrl_hit2 = hits_ctrl(pointer2_high_byte_r, i_ptr_low.ptr2_low);
	assign ctrl_sel  = (i_sfr.sel == `SEL_IND1 && ctrl_hit1) ||
		(i_sfr.sel == `SEL_IND2 && ctrl_hit2);
	assign ctrl_wr   = i_sfr.wr && ctrl_sel;
	// go is judged against the permit already stored, not the one in the same write,
	// so a single stray write can never both enable and launch a cycle
	assign go_fetch  = ctrl_wr && go_ok(i_sfr.wdata[`BIT_FETCH_GO],
		nvm_control_reg_r[`BIT_FETCH_PERMIT], busy_r);
	// fetch wins when software breaks the one-go-at-a-time duty
	assign go_prog   = ctrl_wr && !go_fetch && go_ok(i_sfr.wdata[`BIT_PROG_GO],
		nvm_control_reg_r[`BIT_PROG_PERMIT], busy_r);
	assign start_rd  = go_fetch;
	assign start_wr  = go_prog;

	// storage array with its own read and write timers
	nvm_cell_array u_cells (
		.i_mclk     (i_mclk),
		.i_rst      (i_rst),
		.i_start_rd (start_rd),
		.i_start_wr (start_wr),
		.i_addr     (nvm_address_reg_r),
		.i_wdata    (nvm_data_reg_r),
		.o_rd_done  (rd_done),
		.o_wr_done  (wr_done),
		.o_rdata    (arr_q)
	);

	// next values of the directly addressed registers
	always_comb begin
		addr_nxt = nvm_address_reg_r;
		data_nxt = nvm_data_reg_r;
		p1h_nxt  = pointer1_high_byte_r;
		p2h_nxt  = pointer2_high_byte_r;
		if (i_sfr.wr) begin
			unique case (i_sfr.sel)
				`SEL_ADDR: begin
					addr_nxt = i_sfr.wdata[5:0]; // R15
				end
				`SEL_DATA: begin
					data_nxt = i_sfr.wdata;
				end
				`SEL_PTR1H: begin
					p1h_nxt = i_sfr.wdata;
				end
				`SEL_PTR2H: begin
					p2h_nxt = i_sfr.wdata;
				end
				default: begin
					// indirect accesses change none of these
				end
			endcase
		end
		// a finished read overwrites the data register, which then stays put
		if (rd_done) begin
			data_nxt = arr_q; // R16
		end
	end

	// register the directly addressed registers
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			nvm_address_reg_r    <= `ADDR_RST;
			nvm_data_reg_r       <= `DATA_RST;
			pointer1_high_byte_r <= `PTR_HIGH_RST; // R2
			pointer2_high_byte_r <= `PTR_HIGH_RST; // R2
		end else begin
			nvm_address_reg_r    <= addr_nxt;
			nvm_data_reg_r       <= data_nxt;
			pointer1_high_byte_r <= p1h_nxt;
			pointer2_high_byte_r <= p2h_nxt;
		end
	end

	// next control value: permits follow software, go bits set on acceptance
	always_comb begin
		ctrl_nxt = nvm_control_reg_r;
		if (ctrl_wr) begin
			ctrl_nxt[`BIT_PROG_PERMIT]  = i_sfr.wdata[`BIT_PROG_PERMIT];
			ctrl_nxt[`BIT_FETCH_PERMIT] = i_sfr.wdata[`BIT_FETCH_PERMIT];
		end
		if (go_fetch) begin
			ctrl_nxt[`BIT_FETCH_GO] = 1'b1; // R13
		end
		if (go_prog) begin
			ctrl_nxt[`BIT_PROG_GO] = 1'b1; // R13
		end
		// self clear, so firmware can poll a go bit for the end of its cycle
		if (rd_done) begin
			ctrl_nxt[`BIT_FETCH_GO] = 1'b0; // R13
		end
		if (wr_done) begin
			ctrl_nxt[`BIT_PROG_GO] = 1'b0; // R13
		end
	end

	// control register; reset drops every permit so no write starts by itself
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			nvm_control_reg_r <= `CTRL_RST; // R1
		end else begin
			nvm_control_reg_r <= ctrl_nxt;
		end
	end

	// busy rises with a launch and falls with the matching done pulse
	always_comb begin
		busy_nxt = busy_r;
		if (start_rd || start_wr) begin
			busy_nxt = 1'b1;
		end else if (rd_done || wr_done) begin
			busy_nxt = 1'b0;
		end
	end

	// register busy
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= busy_nxt;
		end
	end

	// done request and vector request
	always_comb begin
		flag_nxt = flag_r;
		if (i_irq_serviced) begin
			flag_nxt = 1'b0; // R7
		end
		// set wins: a write that ends during service must not lose its request
		if (wr_done) begin
			flag_nxt = 1'b1; // R5
		end
		// no fresh vector while the present one is being taken
		vec_nxt = flag_r && i_nvm_done_irq_enable && i_global_irq_enable &&
			!i_stack_full && !i_irq_serviced; // R6
	end

	// register the interrupt state
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			flag_r <= 1'b0;
			vec_r  <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
			vec_r  <= vec_nxt;
		end
	end

	// read mux; data appears one clock after the select
	always_comb begin
		unique case (i_sfr.sel)
			`SEL_ADDR: begin
				rdata_nxt = {2'b00, nvm_address_reg_r}; // R15
			end
			`SEL_DATA: begin
				rdata_nxt = nvm_data_reg_r;
			end
			`SEL_PTR1H: begin
				rdata_nxt = pointer1_high_byte_r;
			end
			`SEL_PTR2H: begin
				rdata_nxt = pointer2_high_byte_r;
			end
			default: begin
				// only a pointer aimed at the control register sees it; upper bits read zero
				rdata_nxt = ctrl_sel ? {4'h0, nvm_control_reg_r} : 8'h00; // R3 R4
			end
		endcase
	end

	// register the read data
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// every output comes straight from a flip-flop
	assign o_sfr_rdata         = rdata_r;
	assign o_nvm_done_irq_flag = flag_r;
	assign o_irq_vector_req    = vec_r;
	assign o_busy              = busy_r;
endmodule

//--- testbench/eeprom_access_guard_chk.sv
// port-level assertions for the eeprom access guard
`include "eeprom_access_guard_defs.svh"
module eeprom_access_guard_chk
	import eeprom_access_guard_pkg::*;
(
	// clock and reset
	input wire logic                              i_mclk,
	input wire logic                              i_rst,
	// register side
	input wire eeprom_access_guard_pkg::sfr_req_t i_sfr,
	input wire logic [7:0]                        o_sfr_rdata,
	// interrupt side and status
	input wire logic                              i_nvm_done_irq_enable,
	input wire logic                              i_global_irq_enable,
	input wire logic                              i_stack_full,
	input wire logic                              i_irq_serviced,
	input wire logic                              o_nvm_done_irq_flag,
	input wire logic                              o_irq_vector_req,
	input wire logic                              o_busy
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	int unsigned run_r;   // cycles spent busy in the current cycle
	int unsigned run_nxt;
	// a stuck busy would hang firmware polling the go bits
	always_comb run_nxt = o_busy ? run_r + 1 : 0;
	always_ff @(posedge i_mclk) run_r <= i_rst ? 0 : run_nxt;
	property p_vec;
		o_irq_vector_req == $past(o_nvm_done_irq_flag && i_nvm_done_irq_enable
			&& i_global_irq_enable && !i_stack_full && !i_irq_serviced);
	endproperty
	a_vec: assert property (p_vec) else $error("vector request mismatch");
	property p_hold;
		o_nvm_done_irq_flag && !i_irq_serviced |=> o_nvm_done_irq_flag;
	endproperty
	a_hold: assert property (p_hold) else $error("done flag dropped");
	property p_clr;
		o_nvm_done_irq_flag && i_irq_serviced && !o_busy |=> !o_nvm_done_irq_flag;
	endproperty
	a_clr: assert property (p_clr) else $error("done flag not cleared");
	property p_set;
		$rose(o_nvm_done_irq_flag) |-> $fell(o_busy);
	endproperty
	a_set: assert property (p_set) else $error("done flag without cycle end");
	property p_start;
		$rose(o_busy) |-> $past(i_sfr.wr && i_sfr.sel[2]);
	endproperty
	a_start: assert property (p_start) else $error("cycle without control write");
	property p_addr;
		i_sfr.sel == 3'h0 |=> o_sfr_rdata[7:6] == 2'h0;
	endproperty
	a_addr: assert property (p_addr) else $error("address upper bits set");
	property p_rst;
		$fell(i_rst) |-> !o_busy && !o_nvm_done_irq_flag && !o_irq_vector_req;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_len;
		run_r <= `WRITE_CYCLES + 8;
	endproperty
	a_len: assert property (p_len) else $error("cycle never ends");
	c_flag: cover property ($rose(o_nvm_done_irq_flag));
	c_vec: cover property ($rose(o_irq_vector_req));
	c_svc: cover property (o_nvm_done_irq_flag && i_irq_serviced);
endmodule
bind eeprom_access_guard eeprom_access_guard_chk u_chk (
	.i_mclk(i_mclk), .i_rst(i_rst), .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata),
	.i_nvm_done_irq_enable(i_nvm_done_irq_enable), .i_global_irq_enable(i_global_irq_enable),
	.i_stack_full(i_stack_full), .i_irq_serviced(i_irq_serviced),
	.o_nvm_done_irq_flag(o_nvm_done_irq_flag), .o_irq_vector_req(o_irq_vector_req),
	.o_busy(o_busy)
);

//--- testbench/tb.sv
// self-checking bench for the eeprom access guard
module tb
	import eeprom_access_guard_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       i_mclk = 0;
	logic       i_rst = 1;
	logic       en = 0;     // done interrupt enable
	logic       glob = 0;   // global interrupt enable
	logic       full = 0;   // call stack full
	logic       svc = 0;    // interrupt serviced pulse
	sfr_req_t   sfr = '0;
	ptr_low_t   plow = '{8'h40, 8'h40};
	logic [7:0] rdata;
	logic       flag, vec, busy;
	int         mismatches = 0;
	int         n_compared = 0;
	always #2 i_mclk = ~i_mclk;
	eeprom_access_guard u_dut (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_sfr(sfr), .i_ptr_low(plow), .o_sfr_rdata(rdata),
		.i_nvm_done_irq_enable(en), .i_global_irq_enable(glob), .i_stack_full(full),
		.i_irq_serviced(svc), .o_nvm_done_irq_flag(flag), .o_irq_vector_req(vec),
		.o_busy(busy)
	);
	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one register write, strobe dropped on the next edge
	task automatic wr(logic [2:0] s, logic [7:0] d);
		@(posedge i_mclk) sfr <= '{1'b1, 1'b0, s, d};
		@(posedge i_mclk) sfr.wr <= 1'b0;
	endtask
	// read data is registered, so it is judged one edge after select
	task automatic rd(logic [2:0] s, logic [7:0] exp, string what);
		@(posedge i_mclk) sfr.sel <= s;
		@(posedge i_mclk) #1 chk(what, rdata, exp);
	endtask
	// the core never halts while a cycle runs, it only polls
	task automatic idle();
		repeat (600) begin
			@(posedge i_mclk) #1;
			if (busy === 1'b0) break;
		end
		chk("busy end", {7'h0, busy}, 8'h00);
	endtask
	task automatic t_sector();
		rd(3'h2, 8'h00, "ptr1 high");
		rd(3'h3, 8'h00, "ptr2 high");
		wr(3'h4, 8'h08);
		wr(3'h4, 8'h0C);
		@(posedge i_mclk) #1 chk("sector0 busy", {7'h0, busy}, 8'h00);
		wr(3'h2, 8'h01);
		@(posedge i_mclk) plow.ptr1_low <= 8'h41;
		wr(3'h4, 8'h08);
		wr(3'h4, 8'h0C);
		@(posedge i_mclk) plow.ptr1_low <= 8'h40;
		#1 chk("low41 busy", {7'h0, busy}, 8'h00);
		rd(3'h4, 8'h00, "ctrl reset");
	endtask
	task automatic t_write();
		wr(3'h0, 8'hFF);
		rd(3'h0, 8'h3F, "addr");
		wr(3'h1, 8'hA5);
		wr(3'h4, 8'h04);
		@(posedge i_mclk) #1 chk("go no permit", {7'h0, busy}, 8'h00);
		// global irq is still low here, and go follows permit at once
		wr(3'h4, 8'h08);
		wr(3'h4, 8'h0C);
		rd(3'h4, 8'h0C, "ctrl go");
		idle();
		rd(3'h4, 8'h08, "ctrl done");
		chk("flag", {7'h0, flag}, 8'h01);
		chk("vec off", {7'h0, vec}, 8'h00);
	endtask
	task automatic t_irq();
		@(posedge i_mclk) {en, glob, full} <= 3'b111;
		repeat (2) @(posedge i_mclk);
		#1 chk("vec full", {7'h0, vec}, 8'h00);
		@(posedge i_mclk) full <= 1'b0;
		repeat (2) @(posedge i_mclk);
		#1 chk("vec", {7'h0, vec}, 8'h01);
		@(posedge i_mclk) glob <= 1'b0;
		repeat (2) @(posedge i_mclk);
		#1 chk("vec glob off", {7'h0, vec}, 8'h00);
		@(posedge i_mclk) glob <= 1'b1;
		@(posedge i_mclk) svc <= 1'b1;
		@(posedge i_mclk) svc <= 1'b0;
		#1 chk("flag svc", {7'h0, flag}, 8'h00);
		chk("vec svc", {7'h0, vec}, 8'h00);
	endtask
	task automatic t_read();
		wr(3'h0, 8'h3F);
		wr(3'h1, 8'h00);
		wr(3'h4, 8'h02);
		wr(3'h4, 8'h03);
		idle();
		rd(3'h1, 8'hA5, "data");
		wr(3'h3, 8'h01);
		rd(3'h5, 8'h02, "ctrl ptr2");
		chk("flag read", {7'h0, flag}, 8'h00);
	endtask
	// mid-run reset: permit and pointers drop, stored bytes survive
	task automatic t_reset();
		wr(3'h2, 8'h01);
		wr(3'h4, 8'h08);
		rd(3'h4, 8'h08, "permit set");
		@(posedge i_mclk) i_rst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		rd(3'h2, 8'h00, "ptr1 after reset");
		rd(3'h3, 8'h00, "ptr2 after reset");
		wr(3'h2, 8'h01);
		rd(3'h4, 8'h00, "permit after reset");
		wr(3'h0, 8'h3F);
		wr(3'h4, 8'h02);
		wr(3'h4, 8'h03);
		idle();
		rd(3'h1, 8'hA5, "byte after reset");
		wr(3'h4, 8'h00);
		wr(3'h2, 8'h00);
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge i_mclk);
		i_rst <= 1'b0;
		t_sector();
		t_write();
		t_irq();
		t_read();
		t_reset();
		give_verdict();
	end
	// whole run is about 620 cycles, so 20 us means a hang
	initial begin
		#20000;
		mismatches++;
		give_verdict();
	end
endmodule
